// ### rtl/brte_engine.sv
// Chosen here: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module brte_engine
  import brte_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic tck,
  input wire logic [17:0] a_pin_in,
  input wire logic [17:0] b_pin_in,
  output brte_pad_type pads
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [35:0] lfsr36(input logic [35:0] v, input logic ab);
    logic fb;
    fb = ^(v & (ab ? BRTE_TAP36_AB : BRTE_TAP36_BA));
    return {v[34:0], fb};
  endfunction

  function automatic logic [17:0] lfsr18(input logic [17:0] v, input logic ab);
    logic fb;
    fb = ^(v & (ab ? BRTE_TAP18_AB : BRTE_TAP18_BA));
    return {v[16:0], fb};
  endfunction

  function automatic brte_mode_type decode_mode(input logic [2:0] sel);
    brte_mode_type m;
    m = BRTE_MODE_TOGGLE;
    if (sel[1:0] == 2'h1)
      m = BRTE_MODE_PATTERN;
    else if (sel[1:0] == 2'h2)
      m = BRTE_MODE_SIGNATURE;
    else if (sel == 3'h3)
      m = BRTE_MODE_SIG_PATTERN;
    else if (sel == 3'h7)
      m = BRTE_MODE_SIG_COUNT;
    return m;
  endfunction

  // ****************************************
  // Input synchronisers
  // ****************************************
  // A change counts only once stages two and three agree, which filters
  // single-sample glitches on the slow test clock.
  logic [36:0] s1_r, s2_r, s3_r, filt_r;
  logic tck_d_r;
  wire logic [36:0] filt_nxt = (s2_r & s3_r) | (filt_r & (s2_r | s3_r));
  wire logic tck_f = filt_r[36];
  wire logic tck_rise = tck_f & ~tck_d_r;
  wire logic tck_fall = ~tck_f & tck_d_r;
  wire logic [35:0] pins36 = filt_r[35:0];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      filt_r <= '0;
      tck_d_r <= 1'b0;
    end
    else
    begin
      s1_r <= {tck, b_pin_in, a_pin_in};
      s2_r <= s1_r;
      s3_r <= s2_r;
      filt_r <= filt_nxt;
      tck_d_r <= tck_f;
    end
  end

  // ****************************************
  // Bus slave
  // ****************************************
  logic [7:0] addr_r;
  logic wr_r, rd_r, rd_done_r;
  logic [31:0] hrdata_r;
  logic [9:0] ctrl_r;
  logic [3:0] enable_r;
  logic [35:0] shift_r, shadow_r;
  brte_pad_type pads_r;

  wire logic accept = hsel & htrans[1] & hready;
  wire logic wr_ctrl = wr_r && addr_r == BRTE_CTRL_ADDR;
  wire logic wr_enable = wr_r && addr_r == BRTE_ENABLE_ADDR;
  wire logic wr_lo = wr_r && addr_r == BRTE_SHIFT_LO_ADDR;
  wire logic wr_hi = wr_r && addr_r == BRTE_SHIFT_HI_ADDR;
  wire logic wr_shift = wr_lo | wr_hi;

  // Reads take one wait state so a write in the preceding data phase is
  // already stored when the read word is sampled.
  assign hreadyout = ~(rd_r & ~rd_done_r);
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;

  // ****************************************
  // Run decision and mode
  // ****************************************
  wire logic [2:0] selector = ctrl_r[2:0]; // R1
  wire brte_mode_type mode = decode_mode(selector); // R2 R3
  wire logic instr_loaded = ctrl_r[BRTE_CTRL_INSTR_BIT];
  wire logic in_idle = ctrl_r[BRTE_CTRL_IDLE_BIT];
  // Enable bits: 0 byte1 A-to-B, 1 byte1 B-to-A, 2 byte2 A-to-B, 3 byte2 B-to-A.
  wire logic dir_valid = (enable_r[0] != enable_r[1]) && (enable_r[0] == enable_r[2])
    && (enable_r[1] == enable_r[3]); // R7
  wire logic run = instr_loaded & in_idle & dir_valid; // R4 R7
  wire logic dir_ab = ~enable_r[0];
  wire logic [35:0] in_mask = dir_ab ? {18'h0_0000, BRTE_HALF_ONES} : {BRTE_HALF_ONES, 18'h0_0000};
  wire logic [35:0] out_mask = ~in_mask;

  wire logic [31:0] status = {27'h000_0000, 1'b0, instr_loaded, dir_ab, dir_valid, run}; // R18

  wire logic [31:0] rd_mux =
    (addr_r == BRTE_CTRL_ADDR) ? {22'h00_0000, ctrl_r} :
    (addr_r == BRTE_ENABLE_ADDR) ? {28'h000_0000, enable_r} :
    (addr_r == BRTE_SHIFT_LO_ADDR) ? shift_r[31:0] :
    (addr_r == BRTE_SHIFT_HI_ADDR) ? {28'h000_0000, shift_r[35:32]} :
    (addr_r == BRTE_SHADOW_LO_ADDR) ? shadow_r[31:0] :
    (addr_r == BRTE_SHADOW_HI_ADDR) ? {28'h000_0000, shadow_r[35:32]} :
    (addr_r == BRTE_STATUS_ADDR) ? status : 32'h0000_0000;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      addr_r <= 8'h00;
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      rd_done_r <= 1'b0;
      hrdata_r <= 32'h0000_0000;
    end
    else
    begin
      if (hreadyout)
      begin
        addr_r <= haddr[7:0];
        wr_r <= accept & hwrite;
        rd_r <= accept & ~hwrite;
      end
      rd_done_r <= rd_r & ~rd_done_r;
      if (rd_r & ~rd_done_r)
        hrdata_r <= rd_mux;
    end
  end

  // ****************************************
  // Control and enable cells
  // ****************************************
  // The enable cells are written only by software; the engine never
  // shifts, toggles or counts them.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_r <= BRTE_CTRL_RESET;
      enable_r <= BRTE_ENABLE_RESET;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_r <= hwdata[9:0]; // R19
      if (wr_enable)
        enable_r <= hwdata[3:0]; // R5
    end
  end

  // ****************************************
  // Next value of the shift stages
  // ****************************************
  wire logic [17:0] in_half = dir_ab ? shift_r[17:0] : shift_r[35:18];
  wire logic [17:0] out_half = dir_ab ? shift_r[35:18] : shift_r[17:0];
  wire logic [17:0] in_pins = dir_ab ? pins36[17:0] : pins36[35:18];
  wire logic [17:0] sig18 = lfsr18(in_half, dir_ab) ^ in_pins; // R15 R21
  wire logic [17:0] count18 = out_half + 18'h0_0001; // R17
  wire logic [17:0] gen18 = (mode == BRTE_MODE_SIG_COUNT) ? count18 : lfsr18(out_half, dir_ab); // R16 R11
  wire logic [35:0] comb36 = dir_ab ? {gen18, sig18} : {sig18, gen18};
  wire logic [35:0] gen36 = lfsr36(shift_r, dir_ab); // R10 R11 R21

  logic [35:0] op_nxt;
  always_comb
  begin
    case (mode)
      BRTE_MODE_TOGGLE: op_nxt = (pins36 & in_mask) | (~shift_r & out_mask); // R8 R9
      BRTE_MODE_PATTERN: op_nxt = gen36; // R10
      BRTE_MODE_SIGNATURE: op_nxt = gen36 ^ (pins36 & in_mask); // R13
      default: op_nxt = comb36; // R15
    endcase
  end

  // A software write to a shift word wins over an engine step that lands
  // in the same cycle, so a seed is never half overwritten.
  wire logic [35:0] shift_nxt =
    wr_lo ? {shift_r[35:32], hwdata} :
    wr_hi ? {hwdata[3:0], shift_r[31:0]} :
    (run & tck_rise) ? op_nxt : shift_r; // R4
  wire logic shadow_load = run & tck_fall & (mode != BRTE_MODE_SIGNATURE); // R14
  wire logic [35:0] shadow_nxt = shadow_load ? ((shift_r & out_mask) | (shadow_r & in_mask)) : shadow_r; // R9 R10

  // ****************************************
  // Pads
  // ****************************************
  // Enable zero puts the port in output mode; the OE stays live in every
  // mode so the enable cells alone decide the drive state.
  brte_pad_type pads_nxt;
  assign pads_nxt.a_out = shadow_r[17:0];
  assign pads_nxt.b_out = shadow_r[35:18];
  assign pads_nxt.a_oe_n = {{9{enable_r[3]}}, {9{enable_r[1]}}}; // R6 R20
  assign pads_nxt.b_oe_n = {{9{enable_r[2]}}, {9{enable_r[0]}}}; // R6 R20
  assign pads = pads_r;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      shift_r <= BRTE_SHIFT_RESET;
      shadow_r <= BRTE_SHIFT_RESET;
      pads_r <= '{default: '1};
    end
    else
    begin
      shift_r <= shift_nxt;
      shadow_r <= shadow_nxt;
      pads_r <= pads_nxt;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence s_step;
    run && tck_rise && !wr_shift;
  endsequence

  sequence s_idle;
    !run && !wr_shift;
  endsequence

  // Signature mode is left out on purpose: its shadows must hold.
  sequence s_fall_load;
    run && tck_fall && mode != BRTE_MODE_SIGNATURE;
  endsequence

  a_mode_decode: assert property (@(posedge hclk) disable iff (!hresetn) // R2
    selector[1:0] == 2'h0 |-> mode == BRTE_MODE_TOGGLE)
    else $error("selector x00 did not pick toggle mode");

  a_combo_decode: assert property (@(posedge hclk) disable iff (!hresetn) // R3
    selector == 3'h7 |-> mode == BRTE_MODE_SIG_COUNT)
    else $error("selector 111 did not pick count mode");

  a_idle_hold: assert property (@(posedge hclk) disable iff (!hresetn) // R4
    s_idle |=> $stable(shift_r))
    else $error("shift cells moved while not running");

  a_bad_dir_bypass: assert property (@(posedge hclk) disable iff (!hresetn) // R7
    !dir_valid |-> !run)
    else $error("engine ran with inconsistent enables");

  a_enables_kept: assert property (@(posedge hclk) disable iff (!hresetn) // R5
    !wr_enable |=> $stable(enable_r))
    else $error("enable cells changed without a write");

  a_toggle_invert: assert property (@(posedge hclk) disable iff (!hresetn) // R9
    s_step ##0 (mode == BRTE_MODE_TOGGLE) |=> ((shift_r ^ $past(shift_r)) & out_mask) == out_mask)
    else $error("output cells did not invert");

  a_zero_stays: assert property (@(posedge hclk) disable iff (!hresetn) // R11
    s_step ##0 (mode == BRTE_MODE_PATTERN && shift_r == 36'h0_0000_0000) |=> shift_r == 36'h0_0000_0000)
    else $error("zero seed produced a pattern");

  a_count_step: assert property (@(posedge hclk) disable iff (!hresetn) // R17
    s_step ##0 (mode == BRTE_MODE_SIG_COUNT) |=> out_half == $past(out_half) + 18'h0_0001)
    else $error("counter did not step by one");

  a_sig_shadow_hold: assert property (@(posedge hclk) disable iff (!hresetn) // R14
    run && mode == BRTE_MODE_SIGNATURE |=> $stable(shadow_r))
    else $error("shadow changed in signature mode");

  a_oe_follow: assert property (@(posedge hclk) disable iff (!hresetn) // R20
    ##1 pads.b_oe_n[0] == $past(enable_r[0]) && pads.a_oe_n[17] == $past(enable_r[3]))
    else $error("output enable does not follow its cell");

  a_sample_pins: assert property (@(posedge hclk) disable iff (!hresetn) // R8
    s_step ##0 (mode == BRTE_MODE_TOGGLE) |=> ((shift_r ^ $past(pins36)) & $past(in_mask)) == 36'h0_0000_0000)
    else $error("input cells did not load their pins");

  a_shadow_copy: assert property (@(posedge hclk) disable iff (!hresetn) // R10
    s_fall_load |=> ((shadow_r ^ $past(shift_r)) & $past(out_mask)) == 36'h0_0000_0000)
    else $error("shadow did not copy the output cells");

endmodule
`default_nettype wire

// ### rtl/brte_pkg.sv
// Notes on behaviour
// [R1] Selector is control bits 2 down to 0.
// [R2] X00 toggle, X01 pattern, X10 signature.
// [R3] 011 signature+pattern, 111 signature+count, 18-bit.
// [R4] Run only with instruction loaded and idle.
// [R5] Control cells 47-36 never join operations.
// [R6] Enable cells still steer output drive state.
// [R7] Bad direction enables fall back to bypass.
// [R8] Toggle mode: input cells load pin values.
// [R9] Toggle mode: output cells invert, shadowed on fall.
// [R10] Pattern mode: 36-bit generator, shadowed on fall.
// [R11] Zero seed keeps generators at zero.
// [R12] Controller should scan a seed first.
// [R13] Signature mode folds inputs into 36 bits.
// [R14] Signature mode: output shadows hold and drive.
// [R15] Combined modes: 18-bit signature on inputs.
// [R16] Combined pattern: 18-bit generator on outputs.
// [R17] Combined count: 18-bit up-counter on outputs.
// [R18] Run-test: bypass bit loads zero, test mode.
// [R19] Controller loads selector before run-test.
// [R20] Enable cell zero means output mode.
// [R21] Fixed maximal polynomials, one per direction.
package brte_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] BRTE_CTRL_ADDR = 8'h00;
  localparam logic [7:0] BRTE_ENABLE_ADDR = 8'h04;
  localparam logic [7:0] BRTE_SHIFT_LO_ADDR = 8'h08;
  localparam logic [7:0] BRTE_SHIFT_HI_ADDR = 8'h0C;
  localparam logic [7:0] BRTE_SHADOW_LO_ADDR = 8'h10;
  localparam logic [7:0] BRTE_SHADOW_HI_ADDR = 8'h14;
  localparam logic [7:0] BRTE_STATUS_ADDR = 8'h18;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int BRTE_CTRL_INSTR_BIT = 8;
  localparam int BRTE_CTRL_IDLE_BIT = 9;
  localparam logic [3:0] BRTE_ENABLE_RESET = 4'hf;
  localparam logic [9:0] BRTE_CTRL_RESET = 10'h000;
  localparam logic [35:0] BRTE_SHIFT_RESET = 36'h0_0000_0000;
  localparam logic [17:0] BRTE_HALF_ONES = 18'h3_ffff;

  // ****************************************
  // Feedback tap masks, one set per direction
  // ****************************************
  localparam logic [35:0] BRTE_TAP36_AB = 36'h8_0100_0000;
  localparam logic [35:0] BRTE_TAP36_BA = 36'h8_0000_0400;
  localparam logic [17:0] BRTE_TAP18_AB = 18'h2_0400;
  localparam logic [17:0] BRTE_TAP18_BA = 18'h2_0040;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    BRTE_MODE_TOGGLE,
    BRTE_MODE_PATTERN,
    BRTE_MODE_SIGNATURE,
    BRTE_MODE_SIG_PATTERN,
    BRTE_MODE_SIG_COUNT
  } brte_mode_type;

  typedef struct packed {
    logic [17:0] a_out;
    logic [17:0] a_oe_n;
    logic [17:0] b_out;
    logic [17:0] b_oe_n;
  } brte_pad_type;

endpackage

// ### tb/brte_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Test controller model
// ****************************************
// The test clock stands still low between frames, so a frame is exactly one step.
// Pins are set with the request and held well ahead of the rising edge.
module brte_ctl_model
(
  input wire logic go,
  input wire logic [35:0] pin_val,
  output logic tck,
  output logic [17:0] a_pin_in,
  output logic [17:0] b_pin_in,
  output logic done
);
  assign {b_pin_in, a_pin_in} = pin_val;
  initial
  begin
    tck = 1'b0;
    done = 1'b0;
  end
  always @(posedge go)
  begin
    done = 1'b0;
    // The edges land on falling system clock edges, midway between rising edges, so the sampler never races them.
    #68 tck = 1'b1;
    #32 tck = 1'b0;
    #32 done = 1'b1;
  end
endmodule
`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
  import brte_pkg::*;
;
  localparam logic [35:0] SEED = 36'h5_a5a5_1234;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic go = 1'b0;
  logic [31:0] haddr = '0;
  logic [31:0] hwdata = '0;
  logic [31:0] rdv;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [35:0] pv = '0;
  logic [35:0] sh;
  logic [35:0] sd;
  logic [7:0] st;
  wire logic hreadyout;
  wire logic hresp;
  wire logic tck;
  wire logic done;
  wire logic [31:0] hrdata;
  wire logic [17:0] a_pin;
  wire logic [17:0] b_pin;
  brte_pad_type pads;
  int n_fail = 0;
  int total_checks = 0;

  brte_engine u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .tck(tck), .a_pin_in(a_pin), .b_pin_in(b_pin), .pads(pads));
  brte_ctl_model u_ctl (.go(go), .pin_val(pv), .tck(tck), .a_pin_in(a_pin), .b_pin_in(b_pin), .done(done));

  always #4 hclk = ~hclk;

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic tally_and_finish;
    if (n_fail == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [71:0] s, input logic [71:0] e);
    total_checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("Error t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 50);
    rdv = hrdata;
    if (n >= 50)
    begin
      n_fail++;
      tally_and_finish();
    end
  endtask

  function automatic logic [35:0] s36(input logic [35:0] v, input logic [35:0] t);
    return {v[34:0], ^(v & t)};
  endfunction

  function automatic logic [17:0] s18(input logic [17:0] v, input logic [17:0] t);
    return {v[16:0], ^(v & t)};
  endfunction

  // One test clock frame with the given selector, enables and seed; results land in sh, sd and st.
  task automatic run(input logic [2:0] sel, input logic [3:0] en, input logic [1:0] rb,
    input logic [35:0] s, input logic [35:0] p);
    int n;
    n = 0;
    ahb(1'b1, BRTE_ENABLE_ADDR, {28'h000_0000, en});
    ahb(1'b1, BRTE_SHIFT_LO_ADDR, s[31:0]);
    ahb(1'b1, BRTE_SHIFT_HI_ADDR, {28'h000_0000, s[35:32]});
    ahb(1'b1, BRTE_CTRL_ADDR, {22'h00_0000, rb, 5'h00, sel});
    @(posedge hclk);
    pv <= p;
    go <= 1'b1;
    do @(posedge hclk); while (done !== 1'b1 && ++n < 100);
    go <= 1'b0;
    repeat (8) @(posedge hclk);
    ahb(1'b0, BRTE_SHIFT_LO_ADDR, '0);
    sh[31:0] = rdv;
    ahb(1'b0, BRTE_SHIFT_HI_ADDR, '0);
    sh[35:32] = rdv[3:0];
    ahb(1'b0, BRTE_SHADOW_LO_ADDR, '0);
    sd[31:0] = rdv;
    ahb(1'b0, BRTE_SHADOW_HI_ADDR, '0);
    sd[35:32] = rdv[3:0];
    ahb(1'b0, BRTE_STATUS_ADDR, '0);
    st = rdv[7:0];
    ahb(1'b1, BRTE_CTRL_ADDR, '0);
    if (n >= 100)
    begin
      n_fail++;
      tally_and_finish();
    end
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    ahb(1'b0, BRTE_ENABLE_ADDR, '0);
    chk(rdv, {28'h000_0000, BRTE_ENABLE_RESET});
    ahb(1'b0, 8'h1c, '0);
    chk(rdv, 32'h0000_0000);
    chk(pads, {18'h0_0000, 18'h3_ffff, 18'h0_0000, 18'h3_ffff});
    chk(hresp, 1'b0);
  endtask

  task automatic t_toggle;
    run(3'h0, 4'ha, 2'h3, SEED, {18'h3_ffff, 18'h2_b3c1});
    chk(sh, {~SEED[35:18], 18'h2_b3c1});
    chk(sd, {~SEED[35:18], 18'h0_0000});
    chk({pads.a_oe_n, pads.b_out, pads.b_oe_n}, {18'h3_ffff, ~SEED[35:18], 18'h0_0000});
    chk(st, 8'h0f);
    run(3'h4, 4'h5, 2'h3, SEED, {18'h1_0f0f, 18'h3_ffff});
    chk(sh, {18'h1_0f0f, ~SEED[17:0]});
    chk({pads.b_oe_n, pads.a_out, pads.a_oe_n}, {18'h3_ffff, ~SEED[17:0], 18'h0_0000});
    chk(st, 8'h0b);
  endtask

  task automatic t_pattern;
    logic [35:0] e;
    e = s36(SEED, BRTE_TAP36_AB);
    run(3'h1, 4'ha, 2'h3, SEED, '1);
    chk(sh, e);
    chk(pads.b_out, e[35:18]);
    run(3'h5, 4'h5, 2'h3, SEED, '1);
    chk(sh, s36(SEED, BRTE_TAP36_BA));
    run(3'h1, 4'ha, 2'h3, '0, '1);
    chk(sh, '0);
  endtask

  task automatic t_signature;
    logic [35:0] prev;
    prev = sd;
    run(3'h2, 4'ha, 2'h3, SEED, {18'h3_ffff, 18'h1_2345});
    chk(sh, s36(SEED, BRTE_TAP36_AB) ^ {18'h0_0000, 18'h1_2345});
    chk(sd, prev);
    run(3'h6, 4'h5, 2'h3, SEED, {18'h0_abcd, 18'h3_ffff});
    chk(sh, s36(SEED, BRTE_TAP36_BA) ^ {18'h0_abcd, 18'h0_0000});
  endtask

  task automatic t_combined;
    run(3'h3, 4'ha, 2'h3, SEED, {18'h3_ffff, 18'h0_5a5a});
    chk(sh, {s18(SEED[35:18], BRTE_TAP18_AB), s18(SEED[17:0], BRTE_TAP18_AB) ^ 18'h0_5a5a});
    run(3'h7, 4'ha, 2'h3, 36'hf_fffc_0011, {18'h3_ffff, 18'h0_0f0f});
    chk(sh, {18'h0_0000, s18(18'h0_0011, BRTE_TAP18_AB) ^ 18'h0_0f0f});
    chk(pads.b_out, 18'h0_0000);
  endtask

  task automatic t_blocked;
    run(3'h1, 4'h0, 2'h3, SEED, '1);
    chk(sh, SEED);
    chk(st[1:0], 2'h0);
    run(3'h1, 4'ha, 2'h1, SEED, '1);
    chk(sh, SEED);
    chk(st[0], 1'b0);
  endtask

  initial
  begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_toggle();
    t_pattern();
    t_signature();
    t_combined();
    t_blocked();
    tally_and_finish();
  end
endmodule
`default_nettype wire
